// ---- logic/uart_regs.vh ----
// Register offsets, field positions, reset values and bit timing for the
// two-channel serial controller. Definitions only; included by bare name.
`ifndef UART_REGS_VH
`define UART_REGS_VH

// Byte offsets: channel registers repeat every CH_STRIDE bytes
`define CH_STRIDE 8'h20
`define OFF_CTL 5'h00
`define OFF_STAT 5'h04
`define OFF_DATA 5'h08
`define OFF_ISTAT 5'h0C
`define OFF_IMASK 5'h10
`define OFF_BAUD 8'h40

// Channel control fields
`define CTL_LEN_LSB 0
`define CTL_PAR_LSB 2
`define CTL_STOP_LSB 4
`define CTL_MODE_LSB 10
`define CTL_RTS 12
`define CTL_RXEN 13
`define CTL_TXEN 14
`define CTL_CTSEN 15
`define CTL_RST 16'h6103

// Baud timer: prescaler in [15:0], source select in bit 16
`define BAUD_EXT 16
`define BAUD_RST 17'h00043

// Parity and channel modes
`define PAR_EVEN 2'h1
`define PAR_ODD 2'h2
`define MODE_NORMAL 2'h0
`define MODE_ECHO 2'h1
`define MODE_LOCAL 2'h2
`define MODE_REMOTE 2'h3

// Interrupt event bits
`define EV_RXRDY 0
`define EV_TXRDY 1
`define EV_OVR 2
`define EV_PERR 3
`define EV_FERR 4
`define EV_CTS 5
`define EV_W 6

// Oversampling: sixteen ticks per bit
`define BIT_LAST 6'h0F
`define HALF_LAST 6'h07
`define STOP_MAX 6'h20

`endif

// ---- logic/uart_tx.v ----
// Serialiser for one channel: start, 5..8 data bits LSB first, parity, stop.
// Assumes a one-cycle tick16 at sixteen times the bit rate.
`timescale 1ns/1ps
`default_nettype none
`include "uart_regs.vh"

module uart_tx (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    input wire ce,
    // Timing and format
    input wire tick16,
    input wire [1:0] len,
    input wire [1:0] par,
    input wire [5:0] stop16,
    // Character in
    input wire start,
    input wire [7:0] data,
    output wire idle,
    // Line
    output reg txd_q
);
    localparam S_IDLE = 3'h0;
    localparam S_START = 3'h1;
    localparam S_DATA = 3'h2;
    localparam S_PAR = 3'h3;
    localparam S_STOP = 3'h4;

    reg [2:0] st_q;
    reg [5:0] cnt_q;
    reg [2:0] bit_q;
    reg [7:0] sh_q;
    reg par_q;
    wire par_on = (par == `PAR_EVEN) || (par == `PAR_ODD);
    wire [2:0] last_bit = 3'h4 + {1'b0, len};
    wire [5:0] stop_len = (stop16 > `STOP_MAX) ? `STOP_MAX :
                          ((stop16 == 6'h00) ? 6'h01 : stop16);
    wire last_tick = (st_q == S_STOP) ? (cnt_q == stop_len - 6'h01) : (cnt_q == `BIT_LAST);

    assign idle = (st_q == S_IDLE);

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= S_IDLE;
            cnt_q <= 6'h00;
            bit_q <= 3'h0;
            sh_q <= 8'h00;
            par_q <= 1'b0;
            txd_q <= 1'b1;
        end else if (ce) begin
            case (st_q)
                S_IDLE: if (start) begin
                    sh_q <= data;
                    par_q <= (par == `PAR_ODD);
                    bit_q <= 3'h0;
                    cnt_q <= 6'h00;
                    st_q <= S_START;
                    txd_q <= 1'b0;
                end
                default: if (tick16) begin
                    if (!last_tick) begin
                        cnt_q <= cnt_q + 6'h01;
                    end else begin
                        cnt_q <= 6'h00;
                        case (st_q)
                            S_START: begin
                                st_q <= S_DATA;
                                txd_q <= sh_q[0];
                            end
                            S_DATA: begin
                                par_q <= par_q ^ sh_q[0];
                                sh_q <= {1'b0, sh_q[7:1]};
                                bit_q <= bit_q + 3'h1;
                                if (bit_q != last_bit) begin
                                    txd_q <= sh_q[1];
                                end else if (par_on) begin
                                    st_q <= S_PAR;
                                    txd_q <= par_q ^ sh_q[0];
                                end else begin
                                    st_q <= S_STOP;
                                    txd_q <= 1'b1;
                                end
                            end
                            S_PAR: begin
                                st_q <= S_STOP;
                                txd_q <= 1'b1;
                            end
                            default: st_q <= S_IDLE;
                        endcase
                    end
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- logic/uart_rx.v ----
// Deserialiser for one channel, oversampling the line sixteen times a bit.
// Assumes rxd synchronous to hclk and a one-cycle tick16.
`timescale 1ns/1ps
`default_nettype none
`include "uart_regs.vh"

module uart_rx (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    input wire ce,
    // Timing and format
    input wire tick16,
    input wire [1:0] len,
    input wire [1:0] par,
    // Line
    input wire rxd,
    // Character out
    output reg valid_q,
    output reg [7:0] data_q,
    output reg perr_q,
    output reg ferr_q
);
    localparam S_IDLE = 3'h0;
    localparam S_START = 3'h1;
    localparam S_DATA = 3'h2;
    localparam S_PAR = 3'h3;
    localparam S_STOP = 3'h4;

    reg [2:0] st_q;
    reg [5:0] cnt_q;
    reg [2:0] bit_q;
    reg [7:0] sh_q;
    reg par_q;
    wire par_on = (par == `PAR_EVEN) || (par == `PAR_ODD);
    wire [2:0] last_bit = 3'h4 + {1'b0, len};
    wire mid = tick16 && (cnt_q == `BIT_LAST);

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= S_IDLE;
            cnt_q <= 6'h00;
            bit_q <= 3'h0;
            sh_q <= 8'h00;
            par_q <= 1'b0;
            valid_q <= 1'b0;
            data_q <= 8'h00;
            perr_q <= 1'b0;
            ferr_q <= 1'b0;
        end else if (ce) begin
            valid_q <= 1'b0;
            if (tick16 && !mid) begin
                cnt_q <= cnt_q + 6'h01;
            end
            case (st_q)
                S_IDLE: if (tick16 && !rxd) begin
                    st_q <= S_START;
                    cnt_q <= 6'h00;
                end
                S_START: if (tick16 && cnt_q == `HALF_LAST) begin
                    // Centre of start bit; a high line was a glitch
                    cnt_q <= 6'h00;
                    bit_q <= 3'h0;
                    par_q <= 1'b0;
                    perr_q <= 1'b0;
                    st_q <= rxd ? S_IDLE : S_DATA;
                end
                S_DATA: if (mid) begin
                    cnt_q <= 6'h00;
                    sh_q <= {rxd, sh_q[7:1]};
                    par_q <= par_q ^ rxd;
                    bit_q <= bit_q + 3'h1;
                    if (bit_q == last_bit) begin
                        st_q <= par_on ? S_PAR : S_STOP;
                    end
                end
                S_PAR: if (mid) begin
                    cnt_q <= 6'h00;
                    perr_q <= ((par_q ^ rxd) != (par == `PAR_ODD));
                    st_q <= S_STOP;
                end
                default: if (mid) begin
                    cnt_q <= 6'h00;
                    data_q <= sh_q >> (2'h3 - len);
                    ferr_q <= !rxd;
                    valid_q <= 1'b1;
                    st_q <= S_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- logic/dual_channel_uart.v ----
// Two-channel serial controller with AHB-Lite register slave and one interrupt.
// Assumes all inputs synchronous to hclk; one slave per bus, single word transfers.
//
// Chosen here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "uart_regs.vh"

module dual_channel_uart (
    // Clock, reset and enable
    input wire hclk,
    input wire hresetn,
    input wire ce,
    // AHB-Lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    // External baud source
    input wire external_timer_clock_in,
    // Serial lines, one bit per channel
    input wire [1:0] rxd,
    output wire [1:0] txd,
    input wire [1:0] cts_n,
    output wire [1:0] rts_n,
    // Interrupt
    output wire irq
);
    localparam NCH = 2;
    // Depths sized to match the queue counters
    localparam [2:0] RX_DEPTH = 3'h4;
    localparam [1:0] TX_DEPTH = 2'h2;

    // Bus, baud timer and interrupt state
    reg wr_q;
    reg rd_q;
    reg [7:0] addr_q;
    reg [16:0] baud_q;
    reg [15:0] pre_cnt_q;
    reg ext_prev_q;
    reg tick16_q;
    reg irq_q;
    reg [31:0] rd_data;

    // Per-channel views for the read mux and the interrupt
    wire [15:0] ctl_w [0:NCH-1];
    wire [6:0] stat_w [0:NCH-1];
    wire [7:0] rxhead_w [0:NCH-1];
    wire [`EV_W-1:0] istat_w [0:NCH-1];
    wire [`EV_W-1:0] imask_w [0:NCH-1];
    wire [NCH-1:0] pend;

    wire take = hsel && hready && htrans[1];
    wire [4:0] off = addr_q[4:0];
    wire ch_sel = addr_q[5];
    wire ch_area = (addr_q[7:6] == 2'h0);
    wire src_ev = baud_q[`BAUD_EXT] ? (external_timer_clock_in && !ext_prev_q) : 1'b1;

    // Writes complete with no wait; reads take one wait for registered data
    // Response is always OKAY; no error cases exist
    assign hreadyout = !rd_q;
    assign hresp = 1'b0;
    assign irq = irq_q;

    // Address phase capture
    // Data phase acts on the captured address
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            addr_q <= 8'h00;
        end else if (ce) begin
            wr_q <= take && hwrite;
            rd_q <= take && !hwrite;
            if (take) begin
                addr_q <= haddr[7:0];
            end
        end
    end

    // Read data select
    // Unmapped offsets read as zero
    always @* begin
        rd_data = 32'h0000_0000;
        if (addr_q == `OFF_BAUD) begin
            rd_data = {15'h0000, baud_q};
        end else if (ch_area && off == `OFF_CTL) begin
            rd_data = {16'h0000, ctl_w[ch_sel]};
        end else if (ch_area && off == `OFF_STAT) begin
            rd_data = {25'h000_0000, stat_w[ch_sel]};
        end else if (ch_area && off == `OFF_DATA) begin
            rd_data = {24'h00_0000, rxhead_w[ch_sel]};
        end else if (ch_area && off == `OFF_ISTAT) begin
            rd_data = {26'h000_0000, istat_w[ch_sel]};
        end else if (ch_area && off == `OFF_IMASK) begin
            rd_data = {26'h000_0000, imask_w[ch_sel]};
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (ce && rd_q) begin
            hrdata <= rd_data;
        end
    end

    // Baud timer shared by both channels
    // External source counts rising edges; prescaler 0 ticks every event
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            baud_q <= `BAUD_RST;
            pre_cnt_q <= 16'h0000;
            ext_prev_q <= 1'b0;
            tick16_q <= 1'b0;
        end else if (ce) begin
            ext_prev_q <= external_timer_clock_in;
            if (wr_q && addr_q == `OFF_BAUD) begin
                baud_q <= hwdata[16:0];
            end
            tick16_q <= 1'b0;
            if (src_ev) begin
                if (pre_cnt_q >= baud_q[15:0]) begin
                    pre_cnt_q <= 16'h0000;
                    tick16_q <= 1'b1;
                end else begin
                    pre_cnt_q <= pre_cnt_q + 16'h0001;
                end
            end
        end
    end

    // One level interrupt for all unmasked status bits
    // Registered, so it follows a new status bit by one cycle
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_q <= 1'b0;
        end else if (ce) begin
            irq_q <= |pend;
        end
    end

    // One copy of control, status and queues per channel
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : chan
            reg [15:0] ctl_q;
            reg [`EV_W-1:0] istat_q;
            reg [`EV_W-1:0] imask_q;
            reg [7:0] rxm_q [0:RX_DEPTH-1];
            reg [1:0] rx_wp_q;
            reg [1:0] rx_rp_q;
            reg [2:0] rx_cnt_q;
            reg [7:0] txm_q [0:TX_DEPTH-1];
            reg tx_wp_q;
            reg tx_rp_q;
            reg [1:0] tx_cnt_q;
            reg cts_prev_q;
            reg txd_q;
            reg [`EV_W-1:0] ev;

            wire hit = ch_area && (ch_sel == g);
            wire [1:0] mode = ctl_q[`CTL_MODE_LSB+1:`CTL_MODE_LSB];
            wire [1:0] len = ctl_q[`CTL_LEN_LSB+1:`CTL_LEN_LSB];
            wire [1:0] par = ctl_q[`CTL_PAR_LSB+1:`CTL_PAR_LSB];
            wire tx_idle;
            wire tx_line;
            wire rx_valid;
            wire [7:0] rx_data;
            wire rx_perr;
            wire rx_ferr;

            // Local loopback feeds the transmitter back to the receiver
            wire rx_line = (mode == `MODE_LOCAL) ? tx_line : rxd[g];
            wire cts_ok = !ctl_q[`CTL_CTSEN] || !cts_n[g];
            wire tx_go = tx_idle && (tx_cnt_q != 2'h0) && ctl_q[`CTL_TXEN] && cts_ok;
            wire tx_push = wr_q && hit && off == `OFF_DATA && tx_cnt_q != TX_DEPTH;
            wire rx_pop = rd_q && hit && off == `OFF_DATA && rx_cnt_q != 3'h0;
            // Remote loopback keeps received characters from software
            wire rx_push = rx_valid && ctl_q[`CTL_RXEN] && mode != `MODE_REMOTE;
            wire rx_full = (rx_cnt_q == RX_DEPTH);

            assign ctl_w[g] = ctl_q;
            assign stat_w[g] = {cts_n[g], !tx_idle, tx_cnt_q, rx_cnt_q};
            assign rxhead_w[g] = rxm_q[rx_rp_q];
            assign istat_w[g] = istat_q;
            assign imask_w[g] = imask_q;
            assign pend[g] = |(istat_q & imask_q);
            assign txd[g] = txd_q;
            assign rts_n[g] = !ctl_q[`CTL_RTS];

            // Overrun only when no pop frees a slot in the same cycle
            always @* begin
                ev = {`EV_W{1'b0}};
                ev[`EV_RXRDY] = rx_push && (!rx_full || rx_pop);
                ev[`EV_TXRDY] = tx_go;
                ev[`EV_OVR] = rx_push && rx_full && !rx_pop;
                ev[`EV_PERR] = rx_valid && rx_perr;
                ev[`EV_FERR] = rx_valid && rx_ferr;
                ev[`EV_CTS] = cts_n[g] != cts_prev_q;
            end

            // Control, mask and sticky status; a new event beats its clear
            // Clear-to-send edges in either direction raise an event
            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    ctl_q <= `CTL_RST;
                    istat_q <= {`EV_W{1'b0}};
                    imask_q <= {`EV_W{1'b0}};
                    cts_prev_q <= 1'b1;
                end else if (ce) begin
                    cts_prev_q <= cts_n[g];
                    if (wr_q && hit && off == `OFF_CTL) begin
                        ctl_q <= hwdata[15:0];
                    end
                    if (wr_q && hit && off == `OFF_IMASK) begin
                        imask_q <= hwdata[`EV_W-1:0];
                    end
                    if (wr_q && hit && off == `OFF_ISTAT) begin
                        istat_q <= (istat_q & ~hwdata[`EV_W-1:0]) | ev;
                    end else begin
                        istat_q <= istat_q | ev;
                    end
                end
            end

            // Receive queue
            // A full queue takes a new character only when a pop frees a slot
            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    rx_wp_q <= 2'h0;
                    rx_rp_q <= 2'h0;
                    rx_cnt_q <= 3'h0;
                end else if (ce) begin
                    if (rx_push && (!rx_full || rx_pop)) begin
                        rxm_q[rx_wp_q] <= rx_data;
                        rx_wp_q <= rx_wp_q + 2'h1;
                    end
                    if (rx_pop) begin
                        rx_rp_q <= rx_rp_q + 2'h1;
                    end
                    if (rx_push && !rx_full && !rx_pop) begin
                        rx_cnt_q <= rx_cnt_q + 3'h1;
                    end else if (rx_pop && !rx_push) begin
                        rx_cnt_q <= rx_cnt_q - 3'h1;
                    end
                end
            end

            // Transmit queue
            // Writes to a full queue are dropped; software polls the count
            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    tx_wp_q <= 1'b0;
                    tx_rp_q <= 1'b0;
                    tx_cnt_q <= 2'h0;
                end else if (ce) begin
                    if (tx_push) begin
                        txm_q[tx_wp_q] <= hwdata[7:0];
                        tx_wp_q <= !tx_wp_q;
                    end
                    if (tx_go) begin
                        tx_rp_q <= !tx_rp_q;
                    end
                    if (tx_push && !tx_go) begin
                        tx_cnt_q <= tx_cnt_q + 2'h1;
                    end else if (tx_go && !tx_push) begin
                        tx_cnt_q <= tx_cnt_q - 2'h1;
                    end
                end
            end

            // Pin driver: echo and remote loopback resend the received line
            // Local loop holds the line idle toward the peer
            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    txd_q <= 1'b1;
                end else if (ce) begin
                    if (mode == `MODE_ECHO || mode == `MODE_REMOTE) begin
                        txd_q <= rxd[g];
                    end else if (mode == `MODE_LOCAL) begin
                        txd_q <= 1'b1;
                    end else begin
                        txd_q <= tx_line;
                    end
                end
            end

            // Both engines share the one baud tick
            uart_tx u_tx (
                .hclk(hclk),
                .hresetn(hresetn),
                .ce(ce),
                .tick16(tick16_q),
                .len(len),
                .par(par),
                .stop16(ctl_q[`CTL_STOP_LSB+5:`CTL_STOP_LSB]),
                .start(tx_go),
                .data(txm_q[tx_rp_q]),
                .idle(tx_idle),
                .txd_q(tx_line)
            );

            uart_rx u_rx (
                .hclk(hclk),
                .hresetn(hresetn),
                .ce(ce),
                .tick16(tick16_q),
                .len(len),
                .par(par),
                .rxd(rx_line),
                .valid_q(rx_valid),
                .data_q(rx_data),
                .perr_q(rx_perr),
                .ferr_q(rx_ferr)
            );
        end
    endgenerate
endmodule
`default_nettype wire

// ---- test/dual_channel_uart_chk.sv ----
// Checker for bus wait states, read data and line timing of the controller.
// Bound into dual_channel_uart; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module dual_channel_uart_chk (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // Bus
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Lines
    input wire logic [1:0] txd,
    input wire logic [1:0] rts_n
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic wr_q;
    wire take = hsel && hready && htrans[1] && ce;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
        end else begin
            wr_q <= take && hwrite;
        end
    end
    sequence rd_take;
        take && !hwrite;
    endsequence
    sequence one_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    a_resp_okay: assert property (hresp == 1'b0) else $error("bad response");
    a_wr_ready: assert property (take && hwrite |=> hreadyout) else $error("write wait");
    a_rd_wait: assert property (rd_take |=> one_wait) else $error("read wait");
    a_wait_single: assert property (!hreadyout |=> hreadyout) else $error("long wait");
    a_data_hold: assert property ($changed(hrdata) |-> !$past(hreadyout))
        else $error("read data moved");
    a_rts_cause: assert property ($changed(rts_n) |-> $past(wr_q))
        else $error("rts moved");
    a_start_zero: assert property ($fell(txd[0]) |=> (!txd[0]) [*8])
        else $error("short start");
    a_start_one: assert property ($fell(txd[1]) |=> (!txd[1]) [*8])
        else $error("short start");
endmodule
bind dual_channel_uart dual_channel_uart_chk chk_u (.hclk(hclk), .hresetn(hresetn),
    .ce(ce), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .txd(txd), .rts_n(rts_n));
`default_nettype wire

// ---- test/serial_peer.sv ----
// Remote serial device: sends and collects 8-bit frames, one stop bit.
// Assumes the controller's clock and a line that idles high.
`timescale 1ns/1ps
`default_nettype none
module serial_peer #(
    parameter int BIT = 16
) (
    // Clock
    input wire logic hclk,
    // Lines
    input wire logic line_in,
    output logic line_out
);
    logic [7:0] got_q [$];
    initial line_out = 1'b1;
    // Start, data LSB first, stop
    task automatic send_char(input logic [7:0] c);
        logic [9:0] f;
        f = {1'b1, c, 1'b0};
        for (int i = 0; i < 10; i++) begin
            line_out <= f[i];
            repeat (BIT) @(posedge hclk);
        end
    endtask
    // Start edge, then bit centres
    initial begin
        logic [7:0] c;
        forever begin
            @(posedge hclk iff line_in === 1'b0);
            repeat (BIT / 2) @(posedge hclk);
            if (line_in === 1'b0) begin
                for (int i = 0; i < 8; i++) begin
                    repeat (BIT) @(posedge hclk);
                    c[i] = line_in;
                end
                repeat (BIT) @(posedge hclk);
                got_q.push_back(c);
            end
        end
    end
endmodule
`default_nettype wire

// ---- test/dual_channel_uart_tb.sv ----
// Testbench: bus master tasks, peer on channel 0, channel 1 in local loop.
// Assumes prescaler 0, so sixteen clocks per bit.
`timescale 1ns/1ps
`default_nettype none
module dual_channel_uart_tb;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] cts_n = 2'h0;
    wire [31:0] hrdata;
    wire hreadyout, hresp, irq, rxd0;
    wire [1:0] txd, rts_n;
    int err_total = 0;
    int compares = 0;
    always #4 hclk = ~hclk;
    dual_channel_uart dut_u (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .external_timer_clock_in(1'b0), .rxd({1'b1, rxd0}), .txd(txd), .cts_n(cts_n),
        .rts_n(rts_n), .irq(irq));
    serial_peer peer_u (.hclk(hclk), .line_in(txd[0]), .line_out(rxd0));
    task automatic close_out();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            err_total++;
        end
    endtask
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1) begin
            err_total++;
            close_out();
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q & m, e);
    endtask
    // Re-read until the field matches or the bound runs out
    task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        int n;
        n = 0;
        do begin
            bus(1'b0, a, 32'h0, q);
            n++;
        end while ((q & m) !== e && n < 200);
        chk(q & m, e);
        if ((q & m) !== e) close_out();
    endtask
    task automatic t_reset();
        rd_chk(8'h00, 32'hFFFF, 32'h6103);
        rd_chk(8'h40, 32'h1FFFF, 32'h00043);
        rd_chk(8'h10, 32'hFFFFFFFF, 32'h0);
        rd_chk(8'h7C, 32'hFFFFFFFF, 32'h0);
        chk({30'h0, rts_n}, 32'h3);
        wr(8'h40, 32'h0);
    endtask
    task automatic t_tx();
        int n;
        cts_n <= 2'h1;
        wr(8'h00, 32'h7103);
        rd_chk(8'h04, 32'h40, 32'h40);
        cts_n <= 2'h0;
        chk({30'h0, rts_n}, 32'h2);
        wr(8'h08, 32'h5A);
        wr(8'h08, 32'hC3);
        wr(8'h08, 32'h11);
        wr(8'h08, 32'h77);
        rd_chk(8'h04, 32'h18, 32'h10);
        n = 0;
        while (n < 1200) begin
            @(posedge hclk);
            n++;
        end
        chk(peer_u.got_q.size(), 3);
        chk({peer_u.got_q[0], peer_u.got_q[1], peer_u.got_q[2]}, 24'h5AC311);
    endtask
    task automatic t_rx();
        for (int i = 0; i < 5; i++) peer_u.send_char(8'h30 + i);
        poll(8'h04, 32'h7, 32'h4);
        rd_chk(8'h0C, 32'h5, 32'h5);
        for (int i = 0; i < 4; i++) rd_chk(8'h08, 32'hFF, 8'h30 + i);
        rd_chk(8'h04, 32'h7, 32'h0);
    endtask
    task automatic t_irq();
        wr(8'h10, 32'h1);
        repeat (2) @(posedge hclk);
        chk({31'h0, irq}, 32'h1);
        wr(8'h10, 32'h0);
        repeat (2) @(posedge hclk);
        chk({31'h0, irq}, 32'h0);
        wr(8'h10, 32'h1);
        wr(8'h0C, 32'h3F);
        repeat (2) @(posedge hclk);
        chk({31'h0, irq}, 32'h0);
    endtask
    // Seven bits, even parity, internal loop on channel 1
    task automatic t_loop();
        wr(8'h20, 32'h6906);
        wr(8'h28, 32'h55);
        repeat (40) @(posedge hclk);
        chk({31'h0, txd[1]}, 32'h1);
        poll(8'h24, 32'h7, 32'h1);
        rd_chk(8'h28, 32'h7F, 32'h55);
        rd_chk(8'h2C, 32'h18, 32'h0);
    endtask
    // Echo and remote loop on channel 0, then transmit held by clear-to-send
    task automatic t_modes();
        wr(8'h00, 32'h7503);
        peer_u.send_char(8'hA5);
        repeat (40) @(posedge hclk);
        chk(peer_u.got_q[3], 8'hA5);
        rd_chk(8'h08, 32'hFF, 32'hA5);
        wr(8'h00, 32'h7D03);
        peer_u.send_char(8'h3C);
        repeat (40) @(posedge hclk);
        chk(peer_u.got_q[4], 8'h3C);
        rd_chk(8'h04, 32'h7, 32'h0);
        cts_n <= 2'h1;
        wr(8'h00, 32'hF103);
        wr(8'h08, 32'h66);
        repeat (40) @(posedge hclk);
        rd_chk(8'h04, 32'h38, 32'h08);
        cts_n <= 2'h0;
        repeat (200) @(posedge hclk);
        chk(peer_u.got_q[5], 8'h66);
    endtask
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_tx();
        t_rx();
        t_irq();
        t_loop();
        t_modes();
        close_out();
    end
endmodule
`default_nettype wire
